// *** rtl/cct_timer_ctrl.sv ***
/*
 * cct_timer_ctrl: 16-bit free-running timer with two captures, two compares,
 * one-pulse and PWM modes, prescaler or external clock, flags and interrupt.
 * Assumes an Avalon-MM master with waitrequest and pins synchronous to sys_clk.
 */

module cct_timer_ctrl
	import cct_pkg::*;
#(
	parameter bit HAS_EXT_CLK = 1'b1,
	parameter bit HAS_CH2     = 1'b1
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// timer pins
	input  wire logic        capture_in_pin_one,
	input  wire logic        capture_in_pin_two,
	input  wire logic        ext_count_clock_pin,
	output logic             compare_out_pin_one,
	output logic             compare_out_pin_one_oe,
	output logic             compare_out_pin_two,
	output logic             compare_out_pin_two_oe,
	// shared interrupt
	output logic             timer_irq
);

	// bus state
	logic        ack_r;
	logic        acc;
	logic        rd_acc;
	logic        wr_acc;
	logic [7:0]  rdata;
	// registers
	logic [7:0]  ctrl_one_r;
	logic [7:0]  ctrl_two_r;
	logic [7:0]  ctrl_two_nxt;
	logic        disable_r;
	logic [15:0] cmp1_r;
	logic [15:0] cmp2_r;
	logic [15:0] cap1_r;
	logic [15:0] cap2_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [2:0]  pre_r;
	logic [4:0]  flags_r;
	logic [4:0]  flags_nxt;
	logic [4:0]  arm_r;
	logic [4:0]  arm_nxt;
	logic [4:0]  flag_set;
	logic [4:0]  flag_acc;
	logic        out1_r;
	logic        out1_nxt;
	logic        out2_r;
	logic        out2_nxt;
	// timing events
	logic        ext_evt;
	logic        cap1_evt_raw;
	logic        cap2_evt_raw;
	logic        cap1_evt;
	logic        cap2_evt;
	logic        pre_tick;
	logic        tick;
	logic        match1;
	logic        match2;
	logic        wrap;
	logic        cnt_clear;
	logic        pwm_mode;
	logic        opm_mode;
	logic [1:0]  cs;

	// one address decode shared by all strobes
	function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
		hit = (a == idx);
	endfunction : hit

	// bus: one wait state, side effects only on the accepting edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign acc             = (avs_read | avs_write) & ack_r;
	assign rd_acc          = avs_read & ack_r;
	assign wr_acc          = avs_write & ack_r & avs_byteenable[0];

	// read mux, unmapped words and missing channel-two words read zero
	always_comb begin
		rdata = 8'h00;
		case (avs_address)
			IDX_CTRL_ONE: rdata = ctrl_one_r;
			IDX_CTRL_TWO: rdata = ctrl_two_r;
			IDX_STATUS:   rdata = {flags_r, disable_r, 2'b00};
			IDX_CAP1_HI:  rdata = cap1_r[15:8];
			IDX_CAP1_LO:  rdata = cap1_r[7:0];
			IDX_CMP1_HI:  rdata = cmp1_r[15:8];
			IDX_CMP1_LO:  rdata = cmp1_r[7:0];
			IDX_CMP2_HI:  rdata = HAS_CH2 ? cmp2_r[15:8] : 8'h00;
			IDX_CMP2_LO:  rdata = HAS_CH2 ? cmp2_r[7:0] : 8'h00;
			IDX_CNT_HI:   rdata = cnt_r[15:8];
			IDX_CNT_LO:   rdata = cnt_r[7:0];
			IDX_ACNT_HI:  rdata = cnt_r[15:8];
			IDX_ACNT_LO:  rdata = cnt_r[7:0];
			IDX_CAP2_HI:  rdata = HAS_CH2 ? cap2_r[15:8] : 8'h00;
			IDX_CAP2_LO:  rdata = HAS_CH2 ? cap2_r[7:0] : 8'h00;
			default:      rdata = 8'h00;
		endcase
	end

	// reduced variant cannot hold the pin-two enable or capture-two edge
	assign ctrl_two_nxt = HAS_CH2 ? avs_writedata[7:0]
	                              : (avs_writedata[7:0] & ~((8'h01 << B_PIN2_EN) | (8'h01 << B_CAP2_EDG)));

	// bus handshake and readback
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_r        <= avs_waitrequest;
			avs_readdata <= {24'h000000, rdata};
		end
	end

	// software-written registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_one_r <= CTRL_RESET;
			ctrl_two_r <= CTRL_RESET;
			disable_r  <= 1'b0;
			cmp1_r     <= CMP_RESET;
			cmp2_r     <= CMP_RESET;
		end else if (wr_acc) begin
			if (hit(avs_address, IDX_CTRL_ONE)) ctrl_one_r <= avs_writedata[7:0];
			if (hit(avs_address, IDX_CTRL_TWO)) ctrl_two_r <= ctrl_two_nxt;
			if (hit(avs_address, IDX_STATUS)) disable_r <= avs_writedata[B_DISABLE];
			if (hit(avs_address, IDX_CMP1_HI)) cmp1_r[15:8] <= avs_writedata[7:0];
			if (hit(avs_address, IDX_CMP1_LO)) cmp1_r[7:0] <= avs_writedata[7:0];
			if (hit(avs_address, IDX_CMP2_HI)) cmp2_r[15:8] <= avs_writedata[7:0];
			if (hit(avs_address, IDX_CMP2_LO)) cmp2_r[7:0] <= avs_writedata[7:0];
		end
	end

	// edge detectors for both capture pins and the external clock
	cct_edge u_cap1 (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.pin_in     (capture_in_pin_one),
		.rise_sel   (ctrl_one_r[B_CAP1_EDG]),
		.edge_pulse (cap1_evt_raw)
	);
	cct_edge u_cap2 (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.pin_in     (capture_in_pin_two),
		.rise_sel   (ctrl_two_r[B_CAP2_EDG]),
		.edge_pulse (cap2_evt_raw)
	);
	cct_edge u_ext (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.pin_in     (ext_count_clock_pin),
		.rise_sel   (ctrl_two_r[B_EXT_EDG]),
		.edge_pulse (ext_evt)
	);

	// mode decode; pwm masks one-pulse and disconnects capture pin one
	assign pwm_mode = ctrl_two_r[B_PWM];
	assign opm_mode = ctrl_two_r[B_ONEPULSE] & ~pwm_mode;
	assign cap1_evt = cap1_evt_raw & ~pwm_mode;
	assign cap2_evt = cap2_evt_raw & HAS_CH2;
	assign cs       = ctrl_two_r[B_CS_HI:B_CS_LO];

	// prescaler terminal counts; external setting without a pin never ticks
	assign pre_tick = (cs == CS_DIV2) ? (pre_r[0] == PRE_END2[0]) :
	                  (cs == CS_DIV4) ? (pre_r[1:0] == PRE_END4[1:0]) :
	                  (cs == CS_DIV8) ? (pre_r == PRE_END8) :
	                  (ext_evt & HAS_EXT_CLK);
	assign tick     = pre_tick & ~disable_r;

	// compare and wrap events on the counting tick
	assign match1 = tick & (cnt_r == cmp1_r);
	assign match2 = tick & (cnt_r == cmp2_r) & HAS_CH2;
	assign wrap   = tick & (cnt_r == CNT_TOP);

	// counter reset by software write to either low byte
	assign cnt_clear = wr_acc & (hit(avs_address, IDX_CNT_LO) | hit(avs_address, IDX_ACNT_LO));

	// counter next value
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_clear) begin
			cnt_nxt = CNT_RESET;
		end else if (opm_mode & cap1_evt & ~disable_r) begin
			cnt_nxt = CNT_RESET;
		end else if (pwm_mode & match2) begin
			cnt_nxt = CNT_RESET;
		end else if (tick) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	// prescaler and counter; disable freezes both, but a low-byte write still clears the counter
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_r <= 3'h0;
			cnt_r <= CNT_RESET;
		end else begin
			pre_r <= disable_r ? pre_r : pre_r + 3'h1;
			cnt_r <= cnt_nxt;
		end
	end

	// capture latches
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cap1_r <= CAP_RESET;
			cap2_r <= CAP_RESET;
		end else begin
			if (cap1_evt) cap1_r <= cnt_r;
			if (cap2_evt) cap2_r <= cnt_r;
		end
	end

	// flag set sources, bit order matches the status layout
	assign flag_set[F_CAP1] = cap1_evt | (pwm_mode & match2);
	assign flag_set[F_CMP1] = match1 & ~pwm_mode;
	assign flag_set[F_OVF]  = wrap;
	assign flag_set[F_CAP2] = cap2_evt;
	assign flag_set[F_CMP2] = match2 & ~pwm_mode;

	// low-byte accesses that finish a clearing sequence; alternate counter excluded
	assign flag_acc[F_CAP1] = acc & hit(avs_address, IDX_CAP1_LO);
	assign flag_acc[F_CMP1] = acc & hit(avs_address, IDX_CMP1_LO);
	assign flag_acc[F_OVF]  = acc & hit(avs_address, IDX_CNT_LO);
	assign flag_acc[F_CAP2] = acc & hit(avs_address, IDX_CAP2_LO);
	assign flag_acc[F_CMP2] = acc & hit(avs_address, IDX_CMP2_LO);

	// a fresh event disarms so the next access cannot clear it: set wins
	assign arm_nxt   = (rd_acc & hit(avs_address, IDX_STATUS)) ? flags_r : (arm_r & ~flag_set & ~flag_acc);
	assign flags_nxt = flag_set | (flags_r & ~(arm_r & flag_acc));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_r <= 5'h00;
			arm_r   <= 5'h00;
		end else begin
			flags_r <= flags_nxt;
			arm_r   <= arm_nxt;
		end
	end

	// compare output one: force first, then mode-dependent events
	always_comb begin
		out1_nxt = out1_r;
		if (ctrl_one_r[B_FORCE1]) begin
			out1_nxt = ctrl_one_r[B_LEVEL1];
		end else if ((pwm_mode & match2) | (opm_mode & cap1_evt & ~disable_r)) begin
			out1_nxt = ctrl_one_r[B_LEVEL2];
		end else if (match1) begin
			out1_nxt = ctrl_one_r[B_LEVEL1];
		end
	end

	// compare output two follows match two outside the pulse modes
	always_comb begin
		out2_nxt = out2_r;
		if (ctrl_one_r[B_FORCE2]) begin
			out2_nxt = ctrl_one_r[B_LEVEL2];
		end else if (match2 & ~pwm_mode & ~opm_mode) begin
			out2_nxt = ctrl_one_r[B_LEVEL2];
		end
	end

	// output levels run whatever the pin enables say
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out1_r <= 1'b0;
			out2_r <= 1'b0;
		end else begin
			out1_r <= out1_nxt;
			out2_r <= out2_nxt;
		end
	end

	// pin enables only route; outside them the pin is general-purpose
	assign compare_out_pin_one    = out1_r;
	assign compare_out_pin_two    = out2_r;
	assign compare_out_pin_one_oe = ctrl_two_r[B_PIN1_EN] & ~disable_r;
	assign compare_out_pin_two_oe = ctrl_two_r[B_PIN2_EN] & ~disable_r & HAS_CH2;

	// shared interrupt from flops only
	assign timer_irq = (ctrl_one_r[B_CAP_IE] & (flags_r[F_CAP1] | flags_r[F_CAP2])) |
	                   (ctrl_one_r[B_CMP_IE] & (flags_r[F_CMP1] | flags_r[F_CMP2])) |
	                   (ctrl_one_r[B_OVF_IE] & flags_r[F_OVF]);

	// checks
	property p_irq;
		@(posedge sys_clk) disable iff (rst)
		(flag_set[F_OVF] && ctrl_one_r[B_OVF_IE]) |=> timer_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("overflow did not raise irq");

	property p_force2;
		@(posedge sys_clk) disable iff (rst)
		ctrl_one_r[B_FORCE2] |=> (out2_r == $past(ctrl_one_r[B_LEVEL2]));
	endproperty
	a_force2: assert property (p_force2) else $error("force two not applied");

	property p_force1;
		@(posedge sys_clk) disable iff (rst)
		ctrl_one_r[B_FORCE1] |=> (out1_r == $past(ctrl_one_r[B_LEVEL1]));
	endproperty
	a_force1: assert property (p_force1) else $error("force one not applied");

	property p_match2;
		@(posedge sys_clk) disable iff (rst)
		(match2 && pwm_mode && !ctrl_one_r[B_FORCE1]) |=> (out1_r == $past(ctrl_one_r[B_LEVEL2])) && (cnt_r == CNT_RESET);
	endproperty
	a_match2: assert property (p_match2) else $error("pwm period end wrong");

	property p_match1;
		@(posedge sys_clk) disable iff (rst)
		(match1 && !ctrl_one_r[B_FORCE1] && !pwm_mode && !opm_mode) |=> (out1_r == $past(ctrl_one_r[B_LEVEL1]));
	endproperty
	a_match1: assert property (p_match1) else $error("match one level not copied");

	property p_cap1;
		@(posedge sys_clk) disable iff (rst)
		cap1_evt |=> (cap1_r == $past(cnt_r)) && flags_r[F_CAP1];
	endproperty
	a_cap1: assert property (p_cap1) else $error("capture one not taken");

	property p_disable;
		@(posedge sys_clk) disable iff (rst)
		(disable_r && !cnt_clear && !(opm_mode && cap1_evt)) |-> !compare_out_pin_one_oe ##1 $stable(cnt_r);
	endproperty
	a_disable: assert property (p_disable) else $error("disabled timer moved");

	property p_wrap;
		@(posedge sys_clk) disable iff (rst)
		(wrap && !cnt_clear && !(pwm_mode && match2) && !(opm_mode && cap1_evt)) |=>
		(cnt_r == 16'h0000) && flags_r[F_OVF];
	endproperty
	a_wrap: assert property (p_wrap) else $error("overflow wrap wrong");

	property p_clear;
		@(posedge sys_clk) disable iff (rst)
		(arm_r[F_OVF] && flag_acc[F_OVF] && !flag_set[F_OVF]) |=> !flags_r[F_OVF];
	endproperty
	a_clear: assert property (p_clear) else $error("armed clear failed");

	property p_div4;
		@(posedge sys_clk) disable iff (rst)
		(tick && cs == CS_DIV4 && !disable_r) ##1 (cs == CS_DIV4 && !disable_r) |-> (!tick || cs != CS_DIV4)[*3];
	endproperty
	a_div4: assert property (p_div4) else $error("divide by four spacing wrong");

endmodule : cct_timer_ctrl

// *** shared/cct_pkg.sv ***
/*
 * cct_pkg: register word indices, field positions, reset values and
 * clock-select codes of the capture/compare timer control block.
 * Assumes a 32-bit Avalon-MM word-addressed slave; data sits in bits 7:0.
 */
package cct_pkg;

	// word indices on the register bus
	localparam logic [3:0] IDX_CTRL_TWO  = 4'h0;
	localparam logic [3:0] IDX_CTRL_ONE  = 4'h1;
	localparam logic [3:0] IDX_STATUS    = 4'h2;
	localparam logic [3:0] IDX_CAP1_HI   = 4'h3;
	localparam logic [3:0] IDX_CAP1_LO   = 4'h4;
	localparam logic [3:0] IDX_CMP1_HI   = 4'h5;
	localparam logic [3:0] IDX_CMP1_LO   = 4'h6;
	localparam logic [3:0] IDX_CMP2_HI   = 4'h7;
	localparam logic [3:0] IDX_CMP2_LO   = 4'h8;
	localparam logic [3:0] IDX_CNT_HI    = 4'h9;
	localparam logic [3:0] IDX_CNT_LO    = 4'ha;
	localparam logic [3:0] IDX_ACNT_HI   = 4'hb;
	localparam logic [3:0] IDX_ACNT_LO   = 4'hc;
	localparam logic [3:0] IDX_CAP2_HI   = 4'hd;
	localparam logic [3:0] IDX_CAP2_LO   = 4'he;

	// timer_control_one fields
	localparam int B_CAP_IE   = 7;
	localparam int B_CMP_IE   = 6;
	localparam int B_OVF_IE   = 5;
	localparam int B_FORCE2   = 4;
	localparam int B_FORCE1   = 3;
	localparam int B_LEVEL2   = 2;
	localparam int B_CAP1_EDG = 1;
	localparam int B_LEVEL1   = 0;

	// timer_control_two fields
	localparam int B_PIN1_EN  = 7;
	localparam int B_PIN2_EN  = 6;
	localparam int B_ONEPULSE = 5;
	localparam int B_PWM      = 4;
	localparam int B_CS_HI    = 3;
	localparam int B_CS_LO    = 2;
	localparam int B_CAP2_EDG = 1;
	localparam int B_EXT_EDG  = 0;

	// timer_flags_status fields; flags occupy bits 7..3 in this order
	localparam int B_FLAG_TOP = 7;
	localparam int B_FLAG_BOT = 3;
	localparam int B_DISABLE  = 2;
	localparam int F_CAP1     = 4;
	localparam int F_CMP1     = 3;
	localparam int F_OVF      = 2;
	localparam int F_CAP2     = 1;
	localparam int F_CMP2     = 0;

	// reset values
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] CNT_RESET    = 16'hfffc;
	localparam logic [15:0] CNT_TOP      = 16'hffff;
	localparam logic [15:0] CMP_RESET    = 16'h8000;
	localparam logic [15:0] CAP_RESET    = 16'h0000;

	// clock-select codes and prescaler terminal counts
	localparam logic [1:0] CS_DIV4 = 2'h0;
	localparam logic [1:0] CS_DIV2 = 2'h1;
	localparam logic [1:0] CS_DIV8 = 2'h2;
	localparam logic [1:0] CS_EXT  = 2'h3;
	localparam logic [2:0] PRE_END2 = 3'h1;
	localparam logic [2:0] PRE_END4 = 3'h3;
	localparam logic [2:0] PRE_END8 = 3'h7;

endpackage : cct_pkg

// *** rtl/cct_edge.sv ***
/*
 * cct_edge: selectable-edge detector for a pin sampled on sys_clk.
 * Assumes the pin is already synchronous to sys_clk.
 */
module cct_edge
	import cct_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// pin and edge choice
	input  wire logic pin_in,
	input  wire logic rise_sel,
	// one-cycle event
	output logic      edge_pulse
);

	logic prev_r;
	logic pulse_nxt;

	// 0 picks falling, 1 picks rising
	assign pulse_nxt = rise_sel ? (pin_in & ~prev_r) : (~pin_in & prev_r);

	// registered pulse keeps the event a clean flop output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev_r     <= 1'b0;
			edge_pulse <= 1'b0;
		end else begin
			prev_r     <= pin_in;
			edge_pulse <= pulse_nxt;
		end
	end

endmodule : cct_edge

// *** testbench/cct_pin_model.sv ***
/*
 * cct_pin_model: far side of the timer pins, the two capture sources and
 * the external count clock. Assumes sys_clk comes from the bench.
 */
module cct_pin_model (
	// clock
	input  wire logic sys_clk,
	// pins toward the timer
	output logic      cap_one,
	output logic      cap_two,
	output logic      ext_clk
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle low; pins only move just after a rising edge
	initial begin
		cap_one = 1'b0;
		cap_two = 1'b0;
		ext_clk = 1'b0;
	end

	// set one pin, then hold it; hold of 1+ keeps ext below sys_clk/2
	task automatic drive(input int sel, input logic lvl, input int hold);
		@(posedge sys_clk);
		case (sel)
			0: cap_one <= lvl;
			1: cap_two <= lvl;
			default: ext_clk <= lvl;
		endcase
		repeat (hold) @(posedge sys_clk);
	endtask : drive
endmodule : cct_pin_model

// *** testbench/test_capture_compare_timer_ctrl.sv ***
/*
 * test_capture_compare_timer_ctrl: directed bench for cct_timer_ctrl.
 * Assumes cct_pin_model drives the capture and external clock pins.
 */
module test_capture_compare_timer_ctrl import cct_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, rst, avs_read, avs_write;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, red_rdata;
	logic        avs_waitrequest, pin1, pin1_oe, pin2, pin2_oe, irq, red_oe2;
	wire logic   cap1, cap2, extc;
	logic [7:0]  q, v0, v1, rr, w0;
	int          failures, checks, cycles, n;
	// capture channel tables: control reg, base value, flag, low byte
	logic [3:0]  cr[2] = '{IDX_CTRL_ONE, IDX_CTRL_TWO};
	logic [7:0]  base[2] = '{8'h00, 8'hc4};
	logic [7:0]  fl[2] = '{8'h80, 8'h10};
	logic [3:0]  lo[2] = '{IDX_CAP1_LO, IDX_CAP2_LO};
	logic [1:0]  cs_tab[3] = '{CS_DIV4, CS_DIV2, CS_DIV8};
	int          dv_tab[3] = '{4, 2, 8};

	cct_timer_ctrl dut (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.capture_in_pin_one(cap1), .capture_in_pin_two(cap2), .ext_count_clock_pin(extc),
		.compare_out_pin_one(pin1), .compare_out_pin_one_oe(pin1_oe),
		.compare_out_pin_two(pin2), .compare_out_pin_two_oe(pin2_oe), .timer_irq(irq)
	);

	cct_pin_model pins (.sys_clk(sys_clk), .cap_one(cap1), .cap_two(cap2), .ext_clk(extc));

	// reduced variant without external pin, sharing the bus; its read data is sampled alongside
	cct_timer_ctrl #(.HAS_EXT_CLK(1'b0), .HAS_CH2(1'b0)) dut_red (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(red_rdata), .avs_waitrequest(),
		.capture_in_pin_one(cap1), .capture_in_pin_two(cap2), .ext_count_clock_pin(extc),
		.compare_out_pin_one(), .compare_out_pin_one_oe(),
		.compare_out_pin_two(), .compare_out_pin_two_oe(red_oe2), .timer_irq()
	);

	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// hang guard, far above the roughly one thousand cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8

	task automatic check_cnt(input int got, input int lo_b, input int hi_b);
		checks++;
		if (got < lo_b || got > hi_b) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, lo_b);
		end
	endtask : check_cnt

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be,
		output logic [7:0] r);
		int k;
		k = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		avs_read <= ~w;
		avs_write <= w;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		r = avs_readdata[7:0];
		rr = red_rdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 50) failures++;
		#1;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, 4'h1, r);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] r);
		bus(1'b0, a, 8'h00, 4'h1, r);
	endtask : rd

	// status read arms, low byte access clears
	task automatic clr(input logic [3:0] a);
		rd(IDX_STATUS, q);
		rd(a, q);
	endtask : clr

	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask : cyc

	// cycles for which pin one keeps the given level, bounded
	task automatic run_len(input logic lvl, output int c);
		c = 0;
		while (pin1 === lvl && c < 400) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask : run_len

	task t_reset;
		rd(IDX_CNT_HI, q);
		check8(q, 8'hff);
		rd(IDX_CTRL_ONE, q);
		check8(q, CTRL_RESET);
		rd(IDX_CTRL_TWO, q);
		check8(q, CTRL_RESET);
		rd(IDX_CMP1_HI, q);
		check8(q, 8'h80);
		rd(4'hf, q);
		check8(q, 8'h00);
		check8({7'h0, pin1_oe | pin2_oe | irq}, 8'h00);
	endtask : t_reset

	task t_disable;
		wr(IDX_STATUS, 8'hfc);
		rd(IDX_STATUS, q);
		check8(q & 8'h07, 8'h04);
		wr(IDX_CTRL_TWO, 8'hc4);
		rd(IDX_CNT_LO, v0);
		cyc(40);
		rd(IDX_CNT_LO, v1);
		check8(v1, v0);
		check8({6'h0, pin1_oe, pin2_oe}, 8'h00);
		wr(IDX_CNT_LO, 8'h00);
		rd(IDX_CNT_LO, q);
		check8(q, 8'hfc);
		bus(1'b1, IDX_CTRL_ONE, 8'hff, 4'h0, q);
		rd(IDX_CTRL_ONE, q);
		check8(q, 8'h00);
		wr(IDX_STATUS, 8'h00);
		check8({6'h0, pin1_oe, pin2_oe}, 8'h03);
	endtask : t_disable

	task t_ovf;
		wr(IDX_CNT_LO, 8'h00);
		cyc(20);
		clr(IDX_ACNT_LO);
		rd(IDX_STATUS, q);
		check8(q & 8'h20, 8'h20);
		rd(IDX_CNT_LO, q);
		rd(IDX_STATUS, q);
		check8(q & 8'h20, 8'h00);
		wr(IDX_CTRL_ONE, 8'h20);
		check8({7'h0, irq}, 8'h00);
		wr(IDX_CNT_LO, 8'h00);
		cyc(20);
		rd(IDX_CNT_LO, q);
		rd(IDX_STATUS, q);
		check8(q & 8'h20, 8'h20);
		check8({7'h0, irq}, 8'h01);
		wr(IDX_CTRL_ONE, 8'h00);
		check8({7'h0, irq}, 8'h00);
		rd(IDX_CNT_LO, q);
	endtask : t_ovf

	// each edge choice: the selected transition flags, the other does not
	task t_cap(input int s);
		for (int e = 0; e < 2; e++) begin
			pins.drive(s, ~e[0], 4);
			wr(cr[s], base[s] | (8'(e) << 1));
			clr(lo[s]);
			pins.drive(s, e[0], 4);
			rd(IDX_STATUS, q);
			check8(q & fl[s], fl[s]);
			if (s == 1) check8(rr & 8'h10, 8'h00);
			clr(lo[s]);
			pins.drive(s, ~e[0], 4);
			rd(IDX_STATUS, q);
			check8(q & fl[s], 8'h00);
		end
	endtask : t_cap

	task t_cmp;
		wr(IDX_CMP1_HI, 8'h00);
		wr(IDX_CMP1_LO, 8'h10);
		wr(IDX_CMP2_HI, 8'h00);
		wr(IDX_CMP2_LO, 8'h20);
		wr(IDX_CTRL_ONE, 8'h05);
		for (int p = 0; p < 2; p++) begin
			wr(IDX_CTRL_TWO, p ? 8'h04 : 8'hc4);
			wr(IDX_CNT_LO, 8'h00);
			cyc(100);
			rd(IDX_STATUS, q);
			check8(q & 8'h48, 8'h48);
			check8(rr & 8'h08, 8'h00);
			clr(IDX_CMP1_LO);
			rd(IDX_CMP2_LO, q);
			check8(rr, 8'h00);
			check8({4'h0, pin1 & pin1_oe, pin2 & pin2_oe, pin1_oe, pin2_oe}, p ? 8'h00 : 8'h0f);
			check8({7'h0, red_oe2}, 8'h00);
		end
		wr(IDX_CTRL_TWO, 8'hc4);
		wr(IDX_CTRL_ONE, 8'h18);
		cyc(2);
		check8({6'h0, pin1, pin2}, 8'h00);
		wr(IDX_CTRL_ONE, 8'h1d);
		cyc(2);
		check8({6'h0, pin1, pin2}, 8'h03);
		wr(IDX_CTRL_ONE, 8'h00);
	endtask : t_cmp

	// read gap is a whole number of prescaler periods, so ticks are exact
	task t_clk;
		for (int i = 0; i < 3; i++) begin
			wr(IDX_CTRL_TWO, {4'h0, cs_tab[i], 2'h0});
			rd(IDX_CNT_LO, v0);
			cyc(16 * dv_tab[i] - 3);
			rd(IDX_CNT_LO, v1);
			check8(v1 - v0, 8'h10);
		end
		for (int e = 0; e < 2; e++) begin
			wr(IDX_CTRL_TWO, 8'h0c | 8'(e));
			for (int l = 1; l >= 0; l--) begin
				rd(IDX_CNT_LO, v0);
				w0 = rr;
				pins.drive(2, l[0], 4);
				rd(IDX_CNT_LO, v1);
				check8(v1 - v0, {7'h0, l[0] == e[0]});
				check8(rr - w0, 8'h00);
			end
		end
	endtask : t_clk

	// pulse 8+5 ticks, period 20h+5 ticks, two cycles a tick
	task t_pwm;
		wr(IDX_CMP1_LO, 8'h08);
		wr(IDX_CMP2_LO, 8'h20);
		wr(IDX_CTRL_ONE, 8'h04);
		clr(IDX_CAP1_LO);
		wr(IDX_CTRL_TWO, 8'hb4);
		wr(IDX_CNT_LO, 8'h00);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, n);
		check_cnt(n, 26, 26);
		run_len(1'b0, n);
		check_cnt(n, 48, 48);
		rd(IDX_STATUS, q);
		check8(q & 8'h80, 8'h80);
	endtask : t_pwm

	// first tick phase after the trigger is free, hence the range
	task t_opm;
		wr(IDX_CTRL_TWO, 8'ha4);
		wr(IDX_CTRL_ONE, 8'h08);
		wr(IDX_CTRL_ONE, 8'h06);
		pins.drive(0, 1'b1, 0);
		run_len(1'b0, n);
		check_cnt(n, 1, 6);
		run_len(1'b1, n);
		check_cnt(n, 24, 27);
		pins.drive(0, 1'b0, 2);
	endtask : t_opm

	// reset, then the scenarios in order
	initial begin
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset;
		t_disable;
		t_ovf;
		t_cap(0);
		t_cap(1);
		t_cmp;
		t_clk;
		t_pwm;
		t_opm;
		print_verdict();
	end
endmodule : test_capture_compare_timer_ctrl
